// >>> logic/prs_i2c_slave.sv
`timescale 1ns/1ps
`default_nettype none
`include "prs_params.svh"
// How it works
// R1 - Answer only slave address 0011000, plus general call when enabled.
// R2 - Slave only: never start transfers, never drive the clock line.
// R3 - Data line driven low only through an enable; released means high.
// R4 - Bits change while clock low; sampled on clock rising edge; bytes of eight.
// R5 - Start is data falling while clock high; it makes the bus active.
// R6 - Master sends seven address bits then the direction bit.
// R7 - Device pulls data low on ninth clock after each accepted byte.
// R8 - Master ack on read continues; not-acknowledge ends transmission.
// R9 - Start while active is a repeated start, new address phase.
// R10 - General call acknowledged only if page 0 register 34 bit 5 set.
// R11 - Each further written byte goes to the next higher register.
// R12 - After master ack, device sends the next higher register.
// R13 - Registers are eight bits, pages of 128 registers.
// R14 - Page 0 after reset; writing register 0 switches page.
// R15 - Page select holds a full eight-bit page number, reset zero.
// R16 - Written values read back; read-only registers ignore writes.
// R17 - Master touches only implemented pages.
// R18 - Master writes only reset values to reserved and read-only bits.
// R19 - Writing one to register 1 bit 0 resets registers; bit self-clears. The code clears only page 0; other pages keep their values.
// R20 - Register 2 of page 0 is reserved and read-only.
// R21 - Stop is data rising while clock high; returns idle.
// R22 - Bytes move MSB first; first written byte is the register pointer.
// R23 - Unmatched or disabled general-call addresses are left unacknowledged.
module prs_i2c_slave
    import prs_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    output logic [7:0] page_select,
    output logic gcall_enable,
    output logic ctrl_reset_pulse
);
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic scl_q;
    logic sda_q;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    prs_state_t state;
    logic [2:0] bit_cnt;
    logic [7:0] shift;
    logic is_read;
    logic ptr_loaded;
    logic [6:0] reg_ptr;
    logic mem_we;
    logic [7:0] mem_wdata;
    logic [14:0] mem_waddr;
    logic [7:0] mem_rdata;
    logic [7:0] tx_byte;
    logic [7:0] next_rx;
    logic addr_bits_seen;
    logic soft_reset;
    logic clear_busy;
    logic [6:0] clear_idx;

    // Two flops on each pin before any logic looks at it.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            scl_sync <= 2'h3;
            sda_sync <= 2'h3;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else if (ce) begin
            scl_sync <= {scl_sync[0], scl_in};
            sda_sync <= {sda_sync[0], sda_in};
            scl_q <= scl_sync[1];
            sda_q <= sda_sync[1];
        end
    end

    assign scl_rise = scl_sync[1] && !scl_q; // R4
    assign scl_fall = !scl_sync[1] && scl_q;
    assign start_det = scl_sync[1] && scl_q && sda_q && !sda_sync[1]; // R5
    assign stop_det = scl_sync[1] && scl_q && !sda_q && sda_sync[1]; // R21
    assign next_rx = {shift[6:0], sda_sync[1]}; // R22
    assign soft_reset = mem_we && page_select == `PRS_PAGE_RESET &&
        reg_ptr == `PRS_REG_SRST && mem_wdata[`PRS_SRST_BIT]; // R19

    // Protocol sequencer.
    // The address is judged on the clock fall that ends its eighth bit.
    // A start also leaves the bit counter at zero, so a flag records that
    // address bits were really shifted in; without it the start's own
    // clock fall would judge whatever byte was left in the shifter.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state <= PRS_IDLE;
            addr_bits_seen <= 1'b0;
            bit_cnt <= `PRS_BIT_ZERO;
            shift <= `PRS_BYTE_ZERO;
            is_read <= 1'b0;
            ptr_loaded <= 1'b0;
            reg_ptr <= `PRS_REG_PAGE;
            sda_out <= 1'b0;
            sda_oe <= 1'b0;
            mem_we <= 1'b0;
            mem_wdata <= `PRS_BYTE_ZERO;
        end else if (ce) begin
            mem_we <= 1'b0;
            sda_out <= 1'b0; // R3 R2
            if (start_det) begin
                state <= PRS_ADDR; // R9
                bit_cnt <= `PRS_BIT_ZERO;
                addr_bits_seen <= 1'b0;
                sda_oe <= 1'b0;
            end else if (stop_det) begin
                state <= PRS_IDLE; // R21
                sda_oe <= 1'b0;
            end else begin
                case (state)
                    PRS_IDLE: begin
                        sda_oe <= 1'b0;
                    end
                    PRS_ADDR: begin
                        if (scl_rise) begin
                            shift <= next_rx;
                            bit_cnt <= bit_cnt + 3'h1;
                            addr_bits_seen <= 1'b1;
                        end
                        if (scl_fall && bit_cnt == `PRS_BIT_ZERO && addr_bits_seen) begin
                            if ((shift[7:1] == `PRS_SLAVE_ADDR) || // R1 R10
                                (shift[7:1] == `PRS_GCALL_ADDR && !shift[0] && gcall_enable)) begin
                                state <= PRS_ACK; // R6 R7
                                sda_oe <= 1'b1;
                                is_read <= shift[0];
                                ptr_loaded <= 1'b0;
                            end else begin
                                state <= PRS_IDLE; // R23
                            end
                        end
                    end
                    PRS_ACK: begin
                        if (scl_fall) begin
                            if (is_read) begin
                                state <= PRS_READ;
                                tx_byte_load();
                            end else begin
                                state <= PRS_WRITE;
                                sda_oe <= 1'b0;
                            end
                        end
                    end
                    PRS_WRITE: begin
                        if (scl_rise) begin
                            shift <= next_rx;
                            bit_cnt <= bit_cnt + 3'h1;
                        end
                        if (scl_fall && bit_cnt == `PRS_BIT_ZERO) begin
                            state <= PRS_ACK; // R7
                            sda_oe <= 1'b1;
                            if (!ptr_loaded) begin
                                reg_ptr <= shift[6:0]; // R22
                                ptr_loaded <= 1'b1;
                            end else begin
                                mem_we <= 1'b1;
                                mem_wdata <= shift;
                            end
                        end
                    end
                    // Each bit goes out after the clock falls and holds through the high phase.
                    PRS_READ: begin
                        if (scl_rise) begin
                            bit_cnt <= bit_cnt + 3'h1;
                        end
                        if (scl_fall) begin
                            if (bit_cnt == `PRS_BIT_ZERO) begin
                                state <= PRS_RACK;
                                sda_oe <= 1'b0;
                                reg_ptr <= reg_ptr + 7'h1; // R12
                            end else begin
                                sda_oe <= !tx_byte[~bit_cnt]; // R4 R22
                            end
                        end
                    end
                    // A released line at the ninth rise is a not-acknowledge and ends the read.
                    PRS_RACK: begin
                        if (scl_rise) begin
                            if (sda_sync[1]) begin
                                state <= PRS_IDLE; // R8
                            end
                        end else if (scl_fall) begin
                            state <= PRS_READ; // R8 R12
                            tx_byte_load();
                        end
                    end
                    default: begin
                        state <= PRS_IDLE;
                    end
                endcase
            end
            // The write strobe is one cycle late, so the pointer moves after the write.
            if (mem_we) begin
                reg_ptr <= reg_ptr + 7'h1; // R11
            end
        end
    end

    task automatic tx_byte_load();
        sda_oe <= !tx_byte[`PRS_LAST_BIT];
        bit_cnt <= `PRS_BIT_ZERO;
    endtask

    // Registers that steer logic are shadowed outside the memory.
    // A soft reset or the clearing walk overrides any write in flight.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            page_select <= `PRS_PAGE_RESET; // R14 R15
            gcall_enable <= 1'b0; // R10
            ctrl_reset_pulse <= 1'b0;
        end else if (ce) begin
            ctrl_reset_pulse <= soft_reset; // R19
            if (soft_reset || clear_busy) begin
                page_select <= `PRS_PAGE_RESET;
                gcall_enable <= 1'b0;
            end else if (mem_we && reg_ptr == `PRS_REG_PAGE) begin
                page_select <= mem_wdata; // R14
            end else if (mem_we && page_select == `PRS_PAGE_RESET &&
                         reg_ptr == `PRS_REG_GCALL) begin
                gcall_enable <= mem_wdata[`PRS_GCALL_BIT];
            end
        end
    end

    // Soft reset walks page 0 clearing its bytes.
    // The walk also runs once after reset, so bus traffic must wait for it.
    // Register writes that arrive while it runs are dropped.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            clear_busy <= 1'b1;
            clear_idx <= `PRS_REG_PAGE;
        end else if (ce) begin
            if (soft_reset) begin
                clear_busy <= 1'b1; // R19
                clear_idx <= `PRS_REG_PAGE;
            end else if (clear_busy) begin
                clear_idx <= clear_idx + 7'h1;
                if (&clear_idx) begin
                    clear_busy <= 1'b0;
                end
            end
        end
    end

    // Page 0 registers 1 and 2 never reach the memory; their read values are fixed below.
    logic mem_wr;
    logic [7:0] wdata_final;
    logic ro_hit;
    assign ro_hit = page_select == `PRS_PAGE_RESET &&
        (reg_ptr == `PRS_REG_RSVD || reg_ptr == `PRS_REG_SRST); // R16 R20 R19
    assign mem_wr = clear_busy || (mem_we && !ro_hit);
    assign wdata_final = clear_busy ? `PRS_BYTE_ZERO : mem_wdata;
    assign mem_waddr = clear_busy ? {`PRS_PAGE_RESET, clear_idx} : {page_select, reg_ptr}; // R13

    prs_reg_mem u_mem (
        .clk(clk),
        .ce(ce),
        .wr_en(mem_wr),
        .wr_addr(mem_waddr),
        .wr_data(wdata_final),
        .rd_addr({page_select, reg_ptr}),
        .rd_data(mem_rdata)
    );

    // Register 0 of every page reads back the page number itself.
    always_comb begin
        if (page_select == `PRS_PAGE_RESET && reg_ptr == `PRS_REG_PAGE) begin
            tx_byte = page_select;
        end else if (page_select == `PRS_PAGE_RESET && reg_ptr == `PRS_REG_SRST) begin
            tx_byte = `PRS_BYTE_ZERO; // R19
        end else if (page_select == `PRS_PAGE_RESET && reg_ptr == `PRS_REG_RSVD) begin
            tx_byte = `PRS_RSVD_VALUE;
        end else if (reg_ptr == `PRS_REG_PAGE) begin
            tx_byte = page_select;
        end else begin
            tx_byte = mem_rdata; // R16
        end
    end
endmodule // prs_i2c_slave
`default_nettype wire

// >>> logic/prs_params.svh
`ifndef PRS_PARAMS_SVH
`define PRS_PARAMS_SVH
`define PRS_SLAVE_ADDR 7'h18
`define PRS_GCALL_ADDR 7'h00
`define PRS_REG_PAGE 7'h00
`define PRS_REG_SRST 7'h01
`define PRS_REG_RSVD 7'h02
`define PRS_REG_GCALL 7'h22
`define PRS_GCALL_BIT 5
`define PRS_SRST_BIT 0
`define PRS_PAGE_RESET 8'h00
`define PRS_BYTE_ZERO 8'h00
`define PRS_RSVD_VALUE 8'h00
`define PRS_LAST_BIT 3'h7
`define PRS_BIT_ZERO 3'h0
`define PRS_PAGE_COUNT 256
`define PRS_REGS_PER_PAGE 128
`endif

// >>> logic/prs_pkg.sv
package prs_pkg;
    typedef enum logic [2:0] {
        PRS_IDLE = 3'b000,
        PRS_ADDR = 3'b001,
        PRS_ACK = 3'b010,
        PRS_WRITE = 3'b011,
        PRS_READ = 3'b100,
        PRS_RACK = 3'b101
    } prs_state_t;
endpackage

// >>> logic/prs_reg_mem.sv
`timescale 1ns/1ps
`default_nettype none
`include "prs_params.svh"
module prs_reg_mem (
    input wire logic clk,
    input wire logic ce,
    input wire logic wr_en,
    input wire logic [14:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic [14:0] rd_addr,
    output logic [7:0] rd_data
);
    logic [7:0] mem [0:`PRS_PAGE_COUNT*`PRS_REGS_PER_PAGE-1];

    always_ff @(posedge clk) begin
        if (ce && wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clk) begin
        if (ce) begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule // prs_reg_mem
`default_nettype wire

// >>> test/prs_checker.sv
`timescale 1ns/1ps
`default_nettype none
module prs_checker (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic [7:0] page_select,
    input wire logic gcall_enable,
    input wire logic ctrl_reset_pulse
);
    logic scl_q;
    logic sda_q;
    logic active;
    logic [3:0] cnt;
    logic [7:0] shreg;
    wire start = scl_in && scl_q && sda_q && !sda_in;
    wire stop = scl_in && scl_q && !sda_q && sda_in;
    always_ff @(posedge clk) begin
        scl_q <= scl_in;
        sda_q <= sda_in;
    end
    // Counts clock rises since the last start, saturating, so 8 marks the address ack slot.
    always_ff @(posedge clk) begin
        if (!reset_n || start) begin
            cnt <= 4'h0;
        end else if (scl_in && !scl_q && cnt != 4'hF) begin
            cnt <= cnt + 4'h1;
        end
    end
    always_ff @(posedge clk) begin
        if (scl_in && !scl_q) begin
            shreg <= {shreg[6:0], sda_in};
        end
    end
    always_ff @(posedge clk) begin
        if (!reset_n || stop) begin
            active <= 1'b0;
        end else if (start) begin
            active <= 1'b1;
        end
    end
    sequence ack_slot;
        sda_oe && cnt == 4'h8;
    endsequence
    sequence srst_done;
        page_select == 8'h00 && !gcall_enable;
    endsequence
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    AST_OUT_LOW: assert property (sda_out == 1'b0) else $error("data driven high");
    AST_OE_SCL_LOW: assert property ($changed(sda_oe) |-> !scl_in) else $error("data moved");
    AST_RESET_STATE: assert property (disable iff (1'b0) !reset_n |=> page_select == 8'h00
        && !gcall_enable && !sda_oe) else $error("reset state wrong");
    AST_PULSE_ONE: assert property (ctrl_reset_pulse |=> !ctrl_reset_pulse) else $error("long pulse");
    AST_SRST_CLEARS: assert property (ctrl_reset_pulse |-> ##[0:200] srst_done) else $error("no clear");
    AST_OE_ACTIVE: assert property (sda_oe |-> active) else $error("drive while idle");
    AST_OE_AFTER_ADDR: assert property (sda_oe |-> cnt >= 4'h8) else $error("drive in address");
    AST_ADDR_MATCH: assert property (ack_slot |-> shreg[7:1] == 7'h18
        || (shreg[7:1] == 7'h00 && gcall_enable)) else $error("wrong address acked");
endmodule // prs_checker
bind prs_i2c_slave prs_checker chk (.clk(clk), .reset_n(reset_n), .ce(ce), .scl_in(scl_in),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .page_select(page_select),
    .gcall_enable(gcall_enable), .ctrl_reset_pulse(ctrl_reset_pulse));
`default_nettype wire

// >>> test/prs_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module prs_master_model (
    output logic scl,
    output logic sda_low,
    input wire logic sda
);
    localparam realtime Q = 31.25;
    logic [8:0] last;
    event done;
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic start();
        #Q sda_low = 1'b0;
        #Q scl = 1'b1;
        #Q sda_low = 1'b1;
        #Q scl = 1'b0;
    endtask
    task automatic stop();
        #Q sda_low = 1'b1;
        #Q scl = 1'b1;
        #Q sda_low = 1'b0;
        #Q;
    endtask
    // Nine clocks: eight data bits then the ack slot; a one releases the line.
    task automatic xb(input logic [8:0] tx);
        for (int i = 8; i >= 0; i--) begin
            #Q sda_low = !tx[i];
            #Q scl = 1'b1;
            #Q last[i] = sda;
            #Q scl = 1'b0;
        end
        ->done;
    endtask
endmodule // prs_master_model
`default_nettype wire

// >>> test/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk, reset_n, ce, sda_out, sda_oe, gcall_enable, ctrl_reset_pulse, scl, m_low;
    logic [7:0] page_select;
    logic [7:0] a;
    logic [7:0] d[3];
    logic [8:0] exp_q[$];
    int fail_count = 0;
    int tests_run = 0;
    int pulses = 0;
    int seed = 10534;
    wire sda = (sda_oe ? sda_out : 1'b1) && !m_low;
    prs_i2c_slave dut (.clk(clk), .reset_n(reset_n), .ce(ce), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .page_select(page_select),
        .gcall_enable(gcall_enable), .ctrl_reset_pulse(ctrl_reset_pulse));
    prs_master_model m (.scl(scl), .sda_low(m_low), .sda(sda));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(negedge clk) if (ctrl_reset_pulse === 1'b1) pulses++;
    task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    always @(m.done) check("bus byte", m.last, exp_q.pop_front());
    task automatic put(input logic [7:0] b, input logic ack);
        exp_q.push_back({b, ack});
        m.xb({b, 1'b1});
    endtask
    task automatic get(input logic [7:0] b, input logic nack);
        exp_q.push_back({b, nack});
        m.xb({8'hFF, nack});
    endtask
    task automatic wr(input logic [7:0] r, input logic [7:0] v);
        m.start();
        put(8'h30, 1'b0);
        put(r, 1'b0);
        put(v, 1'b0);
        m.stop();
    endtask
    task automatic rd(input logic [7:0] r, input logic [7:0] v);
        m.start();
        put(8'h30, 1'b0);
        put(r, 1'b0);
        m.start();
        put(8'h31, 1'b0);
        get(v, 1'b1);
        m.stop();
    endtask
    task automatic test_done();
        $display("checks %0d failures %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #500000;
        fail_count++;
        test_done();
    end
    initial begin
        reset_n = 1'b0;
        ce = 1'b1;
        repeat (12) @(negedge clk);
        reset_n = 1'b1;
        repeat (200) @(negedge clk);
        check("page", {1'b0, page_select}, 9'h000);
        check("gcall", {8'h00, gcall_enable}, 9'h000);
        m.start();
        put(8'h00, 1'b1);
        for (int i = 0; i < 4; i++) begin
            a = 8'($random(seed));
            if (a[7:1] == 7'h18 || a[7:1] == 7'h00) a[7:1] = 7'h55;
            m.start();
            put(a, 1'b1);
        end
        m.stop();
        $display("test address done");
        @(negedge clk) ce = 1'b0;
        m.start();
        put(8'h30, 1'b1);
        m.stop();
        @(negedge clk) ce = 1'b1;
        check("frozen page", {1'b0, page_select}, 9'h000);
        $display("test clock enable done");
        wr(8'h22, 8'h20);
        check("gcall", {8'h00, gcall_enable}, 9'h001);
        m.start();
        put(8'h00, 1'b0);
        m.stop();
        $display("test general call done");
        foreach (d[i]) d[i] = 8'($random(seed));
        m.start();
        put(8'h30, 1'b0);
        put(8'h10, 1'b0);
        foreach (d[i]) put(d[i], 1'b0);
        m.stop();
        m.start();
        put(8'h30, 1'b0);
        put(8'h10, 1'b0);
        m.start();
        put(8'h31, 1'b0);
        foreach (d[i]) get(d[i], i == 2);
        m.stop();
        $display("test auto increment done");
        wr(8'h00, 8'h5F);
        check("page", {1'b0, page_select}, 9'h05F);
        rd(8'h00, 8'h5F);
        wr(8'h00, 8'h00);
        check("page", {1'b0, page_select}, 9'h000);
        $display("test page done");
        wr(8'h01, 8'h00);
        wr(8'h01, 8'h01);
        repeat (300) @(negedge clk);
        check("pulses", 9'(pulses), 9'h001);
        check("gcall", {8'h00, gcall_enable}, 9'h000);
        rd(8'h01, 8'h00);
        rd(8'h10, 8'h00);
        check("pending", 9'(exp_q.size()), 9'h000);
        $display("test soft reset done");
        test_done();
    end
endmodule // testbench
`default_nettype wire
